//--- common/in_ep_consts.vh
// Constants for the per-endpoint IN control block
`ifndef IN_EP_CONSTS_VH
`define IN_EP_CONSTS_VH
`define EP_FIRST 5'h01
`define EP_LAST 5'h0B
`define EP_COUNT 11
`define OFS_INDEX 8'h0E
`define OFS_MAXP 8'h10
`define OFS_CSRL 8'h12
`define OFS_CSRU 8'h13
`define MAXP_RESET 16'h0000
`define CSRL_RESET 8'h00
`define CSRU_RESET 8'h00
`define MAXP_SIZE_MSB 10
`define MAXP_MULT_LSB 11
`define MAXP_MULT_MSB 15
`define B_INCOMP 7
`define B_CLRTOG 6
`define B_SENTSTALL 5
`define B_SENDSTALL 4
`define B_FLUSH 3
`define B_UNDERRUN 2
`define B_NOTEMPTY 1
`define B_PKTRDY 0
`define U_AUTOSET 7
`define U_ISO 6
`define U_DBLBUF 5
`define TT_BULK 1'b0
`define TT_ISO 1'b1
`endif

//--- logic/ep_decode.v
// Address decoder for the endpoint register window
`include "in_ep_consts.vh"
module ep_decode (
	input wire [7:0] addr_i,
	input wire [4:0] index_i,
	output reg sel_index_o,
	output reg sel_maxp_o,
	output reg sel_csrl_o,
	output reg sel_csru_o,
	output wire ep_ok_o,
	output wire [3:0] slot_o
);
	wire [4:0] slot_full;
	assign ep_ok_o = (index_i >= `EP_FIRST) && (index_i <= `EP_LAST);
	assign slot_full = index_i - `EP_FIRST;
	assign slot_o = slot_full[3:0];
	always @* begin
		sel_index_o = 1'b0;
		sel_maxp_o = 1'b0;
		sel_csrl_o = 1'b0;
		sel_csru_o = 1'b0;
		if (addr_i == `OFS_INDEX) begin
			sel_index_o = 1'b1;
		end else if (addr_i == `OFS_MAXP) begin
			sel_maxp_o = 1'b1;
		end else if (addr_i == `OFS_CSRL) begin
			sel_csrl_o = 1'b1;
		end else if (addr_i == `OFS_CSRU) begin
			sel_csru_o = 1'b1;
		end
	end
endmodule // ep_decode

//--- logic/pkt_counter.v
// Packet count tracker of one IN FIFO (zero to two packets)
module pkt_counter (
	input wire clk_i,
	input wire rst_i,
	input wire load_i,
	input wire drop_i,
	input wire clear_i,
	output reg [1:0] count_o
);
	always @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			count_o <= 2'h0;
		end else if (load_i && !drop_i && count_o != 2'h2) begin
			count_o <= count_o + 2'h1;
		end else if (drop_i && !load_i && count_o != 2'h0) begin
			count_o <= count_o - 2'h1;
		end
	end
endmodule // pkt_counter

//--- logic/usb_in_endpoint_control.v
// Per-endpoint IN control and status registers for endpoints 1 to 11
//
// Local design decision: the Wishbone slave port.
`include "in_ep_consts.vh"
module usb_in_endpoint_control (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [1:0] wb_sel_i,
	input wire [15:0] wb_dat_i,
	output reg [15:0] wb_dat_o,
	output reg wb_ack_o,
	output reg wb_err_o,
	input wire [3:0] tok_ep_i,
	input wire tok_in_i,
	input wire tx_done_i,
	input wire iso_short_i,
	input wire [3:0] load_ep_i,
	input wire load_full_i,
	input wire load_done_i,
	output reg tok_stall_o,
	output reg tok_nak_o,
	output reg tok_zlp_o,
	output reg tok_data_o,
	output reg tok_toggle_o,
	output reg [15:0] tok_maxp_o,
	output reg [10:0] flush_mask_o
);
	// Token ports carry the slot number (endpoint minus one)
	reg [15:0] maxp_reg [0:`EP_COUNT-1];
	reg [7:0] csrl_reg [0:`EP_COUNT-1];
	reg [7:0] csru_reg [0:`EP_COUNT-1];
	reg [10:0] toggle_reg;
	reg [4:0] index_reg;
	wire sel_index;
	wire sel_maxp;
	wire sel_csrl;
	wire sel_csru;
	wire ep_ok;
	wire [3:0] slot;
	wire [1:0] cnt [0:`EP_COUNT-1];
	wire req;
	wire wr;
	wire tok_ok;
	wire load_ok;
	reg [7:0] c;
	reg [7:0] t;
	reg sent_stall;
	reg underrun_set;
	reg zlp;
	reg [7:0] csrl_next [0:`EP_COUNT-1];
	reg [10:0] toggle_next;
	reg [10:0] flush_next;
	integer i;
	integer j;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wr = req && wb_we_i && ep_ok;
	assign tok_ok = tok_ep_i < `EP_COUNT;
	assign load_ok = load_ep_i < `EP_COUNT;

	ep_decode u_dec (
		.addr_i(wb_adr_i),
		.index_i(index_reg),
		.sel_index_o(sel_index),
		.sel_maxp_o(sel_maxp),
		.sel_csrl_o(sel_csrl),
		.sel_csru_o(sel_csru),
		.ep_ok_o(ep_ok),
		.slot_o(slot)
	);

	function is_flag_clear;
		input [7:0] wdata;
		input integer bitpos;
		begin
			is_flag_clear = !wdata[bitpos];
		end
	endfunction

	function slot_hit;
		input valid;
		input [3:0] ep;
		input integer idx;
		begin
			slot_hit = valid && (ep == idx);
		end
	endfunction

	// One cycle answer; unmapped address or missing endpoint gets err
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 16'h0000;
			index_reg <= 5'h00;
		end else begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			if (req) begin
				wb_dat_o <= 16'h0000;
				if (sel_index) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {11'h000, index_reg};
					if (wb_we_i && wb_sel_i[0]) begin
						index_reg <= wb_dat_i[4:0];
					end
				end else if (ep_ok && sel_maxp) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= maxp_reg[slot];
				end else if (ep_ok && sel_csrl) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {csru_reg[slot], csrl_reg[slot]};
				end else if (ep_ok && sel_csru) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {8'h00, csru_reg[slot]};
				end else begin
					wb_err_o <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Per-endpoint state
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `EP_COUNT; g = g + 1) begin : gen_cnt
			pkt_counter u_cnt (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.load_i(load_done_i && load_ok && load_ep_i == g),
				.drop_i((tx_done_i && tok_ok && tok_ep_i == g) || flush_mask_o[g]),
				.clear_i(tok_in_i && tok_ok && tok_ep_i == g && tok_stall_o),
				.count_o(cnt[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Lower status next state
	// ------------------------------------------------------------
	// Hardware sets come after firmware clears, so an event is
	// never lost to a firmware write of the status byte in the same cycle
	always @* begin
		c = 8'h00;
		t = 8'h00;
		sent_stall = 1'b0;
		underrun_set = 1'b0;
		toggle_next = toggle_reg;
		flush_next = 11'h000;
		for (j = 0; j < `EP_COUNT; j = j + 1) begin
			c = csrl_reg[j];
			// Firmware byte, only in the cycle of its write
			t = 8'h00;
			sent_stall = 1'b0;
			underrun_set = 1'b0;
			// Software write to the lower register
			if (wr && sel_csrl && wb_sel_i[0] && slot == j) begin
				t = wb_dat_i[7:0];
				if (is_flag_clear(t, `B_INCOMP)) begin
					c[`B_INCOMP] = 1'b0;
				end
				if (is_flag_clear(t, `B_SENTSTALL)) begin
					c[`B_SENTSTALL] = 1'b0;
				end
				if (is_flag_clear(t, `B_UNDERRUN)) begin
					c[`B_UNDERRUN] = 1'b0;
				end
				if (is_flag_clear(t, `B_NOTEMPTY)) begin
					c[`B_NOTEMPTY] = 1'b0;
				end
				c[`B_SENDSTALL] = t[`B_SENDSTALL];
				if (t[`B_CLRTOG]) begin
					toggle_next[j] = 1'b0;
				end
				if (t[`B_PKTRDY]) begin
					c[`B_PKTRDY] = 1'b1;
				end
				if (t[`B_FLUSH]) begin
					flush_next[j] = 1'b1;
					c[`B_PKTRDY] = 1'b0;
				end
			end
			if (slot_hit(load_done_i && load_full_i && load_ok, load_ep_i, j) && csru_reg[j][`U_AUTOSET]) begin
				c[`B_PKTRDY] = 1'b1;
			end
			if (slot_hit(tok_in_i && tok_ok, tok_ep_i, j)) begin
				if (tok_stall_o) begin
					sent_stall = 1'b1;
				end else if (tok_nak_o || tok_zlp_o) begin
					underrun_set = 1'b1;
				end
			end
			// clear on transmit, or early when double buffered
			if (slot_hit(tx_done_i && tok_ok, tok_ep_i, j)) begin
				toggle_next[j] = ~toggle_reg[j];
				c[`B_PKTRDY] = 1'b0;
			end
			if (csru_reg[j][`U_DBLBUF] && cnt[j] == 2'h1 && c[`B_PKTRDY] && !t[`B_PKTRDY]) begin
				c[`B_PKTRDY] = 1'b0;
			end
			// stall sent flushes and clears ready
			if (sent_stall) begin
				c[`B_SENTSTALL] = 1'b1;
				c[`B_PKTRDY] = 1'b0;
				flush_next[j] = 1'b1;
			end
			if (underrun_set) begin
				c[`B_UNDERRUN] = 1'b1;
			end
			if (slot_hit(iso_short_i && tok_ok, tok_ep_i, j) && csru_reg[j][`U_ISO]) begin
				c[`B_INCOMP] = 1'b1;
			end
			if (cnt[j] != 2'h0) begin
				c[`B_NOTEMPTY] = 1'b1;
			end
			c[`B_CLRTOG] = 1'b0;
			c[`B_FLUSH] = 1'b0;
			csrl_next[j] = c;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			toggle_reg <= 11'h000;
			flush_mask_o <= 11'h000;
			for (i = 0; i < `EP_COUNT; i = i + 1) begin
				maxp_reg[i] <= `MAXP_RESET;
				csrl_reg[i] <= `CSRL_RESET;
				csru_reg[i] <= `CSRU_RESET;
			end
		end else begin
			toggle_reg <= toggle_next;
			flush_mask_o <= flush_next;
			for (i = 0; i < `EP_COUNT; i = i + 1) begin
				csrl_reg[i] <= csrl_next[i];
				// full sixteen bits stored as written
				if (wr && sel_maxp && slot == i) begin
					if (wb_sel_i[0]) begin
						maxp_reg[i][7:0] <= wb_dat_i[7:0];
					end
					if (wb_sel_i[1]) begin
						maxp_reg[i][15:8] <= wb_dat_i[15:8];
					end
				end
				if (wr && slot == i && ((sel_csrl && wb_sel_i[1]) || (sel_csru && wb_sel_i[0]))) begin
					csru_reg[i] <= sel_csrl ? wb_dat_i[15:8] : wb_dat_i[7:0];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Token answer
	// ------------------------------------------------------------
	// stall while bit set, not iso
	always @* begin
		tok_stall_o = 1'b0;
		tok_nak_o = 1'b0;
		tok_zlp_o = 1'b0;
		tok_data_o = 1'b0;
		zlp = 1'b0;
		if (tok_ok) begin
			if (csrl_reg[tok_ep_i][`B_SENDSTALL] && !csru_reg[tok_ep_i][`U_ISO]) begin
				tok_stall_o = 1'b1;
			end else if (cnt[tok_ep_i] != 2'h0) begin
				tok_data_o = 1'b1;
			end else if (csru_reg[tok_ep_i][`U_ISO]) begin
				zlp = 1'b1;
				tok_zlp_o = zlp;
			end else begin
				tok_nak_o = 1'b1;
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			tok_toggle_o <= 1'b0;
			tok_maxp_o <= 16'h0000;
		end else if (tok_ok) begin
			tok_toggle_o <= toggle_reg[tok_ep_i];
			tok_maxp_o <= maxp_reg[tok_ep_i];
		end
	end
endmodule // usb_in_endpoint_control

//--- tb/in_ep_chk.sv
// Assertion checker for the IN endpoint control block
module in_ep_chk (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [1:0] wb_sel_i,
	input wire [15:0] wb_dat_i,
	input wire wb_ack_o,
	input wire wb_err_o,
	input wire [3:0] tok_ep_i,
	input wire tok_in_i,
	input wire tok_stall_o,
	input wire tok_nak_o,
	input wire tok_zlp_o,
	input wire tok_data_o,
	input wire [10:0] flush_mask_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [4:0] idx_reg;
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire ep_reg = wb_adr_i == 8'h10 || wb_adr_i == 8'h12 || wb_adr_i == 8'h13;
	wire idx_ok = idx_reg >= 5'h01 && idx_reg <= 5'h0B;
	wire [3:0] ans = {tok_stall_o, tok_nak_o, tok_zlp_o, tok_data_o};
	// -----------------------------------------------
	// Index shadow, only the low five bits decode
	// -----------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			idx_reg <= 5'h00;
		end else if (take && wb_we_i && wb_adr_i == 8'h0E && wb_sel_i[0]) begin
			idx_reg <= wb_dat_i[4:0];
		end
	end
	sequence s_take;
		take;
	endsequence
	sequence s_answer;
		(wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
	endsequence
	property p_answer;
		s_take |=> s_answer;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer wrong");
	property p_bad_index;
		take && ep_reg && !idx_ok |=> wb_err_o;
	endproperty
	a_bad_index: assert property (p_bad_index) else $error("bad index accepted");
	property p_good_index;
		take && ep_reg && idx_ok |=> wb_ack_o;
	endproperty
	a_good_index: assert property (p_good_index) else $error("good index refused");
	property p_unmapped;
		take && !ep_reg && wb_adr_i != 8'h0E |=> wb_err_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
	property p_onehot;
		tok_in_i && tok_ep_i <= 4'hA |-> $onehot(ans);
	endproperty
	a_onehot: assert property (p_onehot) else $error("token answer not one");
	property p_no_slot;
		tok_ep_i > 4'hA |-> ans == 4'h0;
	endproperty
	a_no_slot: assert property (p_no_slot) else $error("answer for no slot");
	property p_stall_flush;
		tok_in_i && tok_stall_o && tok_ep_i <= 4'hA |=> flush_mask_o[$past(tok_ep_i)];
	endproperty
	a_stall_flush: assert property (p_stall_flush) else $error("stall without flush");
	property p_flush_pulse;
		flush_mask_o != 11'h000 |=> flush_mask_o == 11'h000;
	endproperty
	a_flush_pulse: assert property (p_flush_pulse) else $error("flush too long");
endmodule // in_ep_chk
bind usb_in_endpoint_control in_ep_chk u_in_ep_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.tok_ep_i(tok_ep_i), .tok_in_i(tok_in_i), .tok_stall_o(tok_stall_o), .tok_nak_o(tok_nak_o),
	.tok_zlp_o(tok_zlp_o), .tok_data_o(tok_data_o), .flush_mask_o(flush_mask_o)
);

//--- tb/usb_host_model.sv
// Behavioural USB host issuing IN tokens
module usb_host_model (
	input wire clk_i,
	input wire [4:0] ans_i,
	output logic [3:0] tok_ep_o = 4'h0,
	output logic tok_in_o = 1'b0,
	output logic tx_done_o = 1'b0,
	output logic iso_short_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy = 1'b0;
	logic [3:0] pat = 4'h0;
	logic [3:0] slot_q = 4'h0;
	// Slot wanders between tokens so a stale slot is never relied on
	always @(posedge clk_i) begin
		pat <= pat + 4'h7;
		tok_ep_o <= busy ? slot_q : pat;
	end
	task automatic in_token(input logic [3:0] slot, input logic short, output logic [4:0] ans);
		busy = 1'b1;
		slot_q = slot;
		@(posedge clk_i);
		tok_in_o <= 1'b1;
		iso_short_o <= short;
		@(posedge clk_i);
		ans = ans_i;
		tok_in_o <= 1'b0;
		iso_short_o <= 1'b0;
		tx_done_o <= ans_i[1];
		@(posedge clk_i);
		ans[0] = ans_i[0];
		tx_done_o <= 1'b0;
		busy = 1'b0;
	endtask
endmodule // usb_host_model

//--- tb/usb_in_endpoint_control_tb_top.sv
// Self-checking bench for the IN endpoint control block
module usb_in_endpoint_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, load_full = 1'b0, load_done = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [1:0] sel = 2'b00;
	logic [15:0] dat = 16'h0000;
	logic [3:0] load_ep = 4'h0;
	logic [31:0] seed = 32'hE9E7;
	logic [15:0] maxp_exp [1:11];
	logic [32:0] exp_q [$];
	logic [32:0] cur;
	logic [4:0] a;
	wire [15:0] wb_dat_o, tok_maxp_o;
	wire [10:0] flush_mask_o;
	wire [3:0] tok_ep;
	wire wb_ack_o, wb_err_o, tok_in, tx_done, iso_short, tok_stall_o, tok_nak_o, tok_zlp_o, tok_data_o, tok_toggle_o;
	int mismatches = 0, check_count = 0;
	usb_in_endpoint_control u_usb_in_endpoint_control (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.tok_ep_i(tok_ep), .tok_in_i(tok_in), .tx_done_i(tx_done), .iso_short_i(iso_short), .load_ep_i(load_ep),
		.load_full_i(load_full), .load_done_i(load_done), .tok_stall_o(tok_stall_o), .tok_nak_o(tok_nak_o),
		.tok_zlp_o(tok_zlp_o), .tok_data_o(tok_data_o), .tok_toggle_o(tok_toggle_o), .tok_maxp_o(tok_maxp_o),
		.flush_mask_o(flush_mask_o)
	);
	usb_host_model u_usb_host_model (
		.clk_i(clk_i), .ans_i({tok_stall_o, tok_nak_o, tok_zlp_o, tok_data_o, tok_toggle_o}),
		.tok_ep_o(tok_ep), .tok_in_o(tok_in), .tx_done_o(tx_done), .iso_short_o(iso_short)
	);
	// -----------------------------------------------
	// Helpers
	// -----------------------------------------------
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] ad, input logic [15:0] d, input logic [15:0] m, input logic e);
		int n;
		n = 0;
		exp_q.push_back({e, m, d});
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		dat <= d;
		sel <= 2'b11;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		chk(n < 20, "bus hang");
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [15:0] d);
		wb(1'b1, ad, d, 16'h0000, 1'b0);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [15:0] d, input logic [15:0] m);
		wb(1'b0, ad, d, m, 1'b0);
	endtask
	task automatic tok(input logic short, input logic [3:0] e);
		u_usb_host_model.in_token(4'h2, short, a);
		chk(a[4:1] === e, "token answer");
		chk(tok_maxp_o === maxp_exp[3], "payload limit");
	endtask
	task automatic load(input logic full);
		load_ep <= 4'h2;
		load_full <= full;
		load_done <= 1'b1;
		@(posedge clk_i);
		load_done <= 1'b0;
		load_full <= 1'b0;
		@(posedge clk_i);
	endtask
	// Result watcher, oldest note first
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
			cur = exp_q.pop_front();
			chk(wb_err_o === cur[32] && (wb_dat_o & cur[31:16]) === (cur[15:0] & cur[31:16]), "bus result");
		end
	end
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		repeat (3000) @(posedge clk_i);
		chk(1'b0, "watchdog");
		finish_test();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wr(8'h0E, 16'h0005);
		rd(8'h10, 16'h0000, 16'hFFFF);
		rd(8'h12, 16'h0000, 16'hFFFF);
		// multiplier field may take any value up to 31
		for (int i = 1; i <= 11; i++) begin
			maxp_exp[i] = (i == 3) ? 16'h0A00 : rnd();
			wr(8'h0E, {11'h007, i[4:0]});
			wr(8'h10, maxp_exp[i]);
		end
		for (int i = 1; i <= 11; i++) begin
			wr(8'h0E, {11'h000, i[4:0]});
			rd(8'h10, maxp_exp[i], 16'hFFFF);
		end
		wr(8'h0E, 16'h0000);
		wb(1'b0, 8'h10, 16'h0000, 16'h0000, 1'b1);
		wr(8'h0E, 16'h000C);
		wb(1'b0, 8'h12, 16'h0000, 16'h0000, 1'b1);
		wb(1'b1, 8'h20, 16'h0000, 16'h0000, 1'b1);
		$display("test window done");
		// slot 2 uses a legal high-bandwidth setting, ready set after load
		wr(8'h0E, 16'h0003);
		load(1'b0);
		wr(8'h12, 16'h0001);
		wr(8'h12, 16'h0003);
		rd(8'h12, 16'h0003, 16'h00FF);
		tok(1'b0, 4'b0001);
		rd(8'h12, 16'h0002, 16'h00FF);
		tok(1'b0, 4'b0100);
		chk(a[0] === 1'b1, "toggle after data");
		rd(8'h12, 16'h0006, 16'h00FF);
		$display("test ready done");
		wr(8'h12, 16'h0050);
		load(1'b0);
		wr(8'h12, 16'h0011);
		tok(1'b0, 4'b1000);
		chk(a[0] === 1'b0, "toggle kept");
		wr(8'h12, 16'h0030);
		rd(8'h12, 16'h0030, 16'h00FF);
		wr(8'h12, 16'h0000);
		tok(1'b0, 4'b0100);
		$display("test stall done");
		wr(8'h12, 16'h4010);
		tok(1'b1, 4'b0010);
		rd(8'h12, 16'h4094, 16'hFFFF);
		wr(8'h12, 16'h8000);
		load(1'b1);
		rd(8'h12, 16'h8003, 16'hFFFF);
		// flush while the packet is ready; flush clears ready whether or not it was set
		wr(8'h12, 16'h800A);
		rd(8'h12, 16'h8002, 16'hFFFF);
		$display("test iso flush done");
		// a 64-byte payload, legal for full-speed bulk
		maxp_exp[3] = 16'h0040;
		wr(8'h10, maxp_exp[3]);
		rd(8'h10, 16'h0040, 16'hFFFF);
		wr(8'h12, 16'h2000);
		load(1'b0);
		wr(8'h12, 16'h2001);
		rd(8'h12, 16'h2002, 16'hFFFF);
		load(1'b0);
		wr(8'h12, 16'h2001);
		rd(8'h12, 16'h2003, 16'hFFFF);
		tok(1'b0, 4'b0001);
		rd(8'h12, 16'h2002, 16'hFFFF);
		$display("test double buffer done");
		finish_test();
	end
endmodule // usb_in_endpoint_control_tb_top
